// ===== include/ar_seq_regs.svh
// Purpose: register map, field positions and timing figures of the sequencer
// Assumes: 32-bit register port, 16-bit settings in the low bits
// Notes:   each number lives here once and is used by name
`ifndef AR_SEQ_REGS_SVH
`define AR_SEQ_REGS_SVH

`define AR_ADDR_W          8
`define AR_DATA_W          32
`define AR_SET_W           16
// register byte offsets
`define AR_OFS_CTRL        8'h00
`define AR_OFS_DEAD_SP     8'h04
`define AR_OFS_DEAD_3P     8'h08
`define AR_OFS_FOLLOW      8'h0c
`define AR_OFS_RECLAIM     8'h10
`define AR_OFS_PULSE       8'h14
`define AR_OFS_STATUS      8'h18
// reset values, in timebase ticks where a time
`define AR_RST_CTRL        16'h0001
`define AR_RST_DEAD_SP     16'h01f4
`define AR_RST_DEAD_3P     16'h03e8
`define AR_RST_FOLLOW      16'h0064
`define AR_RST_RECLAIM     16'h1388
`define AR_RST_PULSE       16'h0064
// status field layout
`define AR_ST_STATE_LSB    0
`define AR_ST_SHOT_LSB     4
`define AR_ST_FLAG_LSB     8
`define AR_ST_USED_W       14
// timebase: one tick per millisecond at the 8 ns clock
`define AR_CLK_PERIOD_NS   8
`define AR_TICK_NS         1000000
`define AR_TICK_CYCLES     (`AR_TICK_NS / `AR_CLK_PERIOD_NS)

`endif

// ===== include/ar_seq_pkg.sv
// Purpose: types shared by the autoreclose sequencer
// Assumes: nothing beyond the standard language
// Notes:   no constants here, they live in the register header
package ar_seq_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_WAITCLR = 4'b0001,
    ST_DEAD    = 4'b0010,
    ST_CLOSE1  = 4'b0011,
    ST_WAITC1  = 4'b0100,
    ST_FOLLOW  = 4'b0101,
    ST_CLOSE2  = 4'b0110,
    ST_RECLAIM = 4'b0111,
    ST_LOCKOUT = 4'b1000
  } seq_state_type;

  // control register fields, msb first
  typedef struct packed {
    logic [9:0] spare;
    logic [1:0] max_shots;                      // shots allowed minus one
    logic       lead_two_first_shot_sync_check;
    logic       lead_one_first_shot_sync_check;
    logic       single_phase_mode;
    logic       enable;
  } ctrl_type;

  // conditioned field inputs
  typedef struct packed {
    logic reset_lockout;
    logic sync_ok_two;
    logic sync_ok_one;
    logic cb2_closed;
    logic cb1_closed;
    logic trip_single_pole;
    logic trip;
  } field_in_type;

endpackage

// ===== rtl/ar_seq.sv
// Purpose: two-breaker autoreclose sequencer (leader closes, follower after)
// Assumes: field inputs are asynchronous levels; register port on clk_i
// Notes:   all intervals count a common millisecond tick
// Notes on behaviour
// - trip during reclaim starts another shot, or locks out on the last shot
// - single-pole cycle on first shot only
// - both in-progress outputs rise with the trip
// - dead timer after both open, trip reset
// - follower timer starts when leader reports closed
// - follower expiry pulses the second close
// - reclaim starts when second close pulse ends
// - quiet reclaim end flags success per breaker
// - last-shot reclaim trip locks out, clears both in-progress
// - after first trip, later shots are three-pole
// - separate single-phase and three-phase dead timers
// - first three-phase shot may wait for sync check
// - lockout and alarm held until reset pulse
// - each shot's dead timer starts at its shot
//
// Decided for this implementation: strobed register access and the address map.
`include "ar_seq_regs.svh"

module ar_seq #(
  parameter int TICK_CYCLES = `AR_TICK_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [`AR_ADDR_W-1:0] addr_i,
  input  wire logic [`AR_DATA_W-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [`AR_DATA_W-1:0] rdata_o,
  input  wire logic                  trip_i,
  input  wire logic                  trip_single_pole_i,
  input  wire logic                  cb1_closed_i,
  input  wire logic                  cb2_closed_i,
  input  wire logic                  sync_ok_one_i,
  input  wire logic                  sync_ok_two_i,
  input  wire logic                  reset_lockout_i,
  output logic      [1:0]            reclose_in_progress_o,
  output logic                       close_one_o,
  output logic                       close_two_o,
  output logic      [1:0]            success_o,
  output logic                       lockout_o,
  output logic                       alarm_o,
  output logic                       force_three_pole_o
);

  ar_seq_pkg::ctrl_type      ctrl_ff;
  ar_seq_pkg::field_in_type  meta_ff;
  ar_seq_pkg::field_in_type  in_ff;
  ar_seq_pkg::seq_state_type state_ff;
  ar_seq_pkg::seq_state_type nxt_state;
  logic [`AR_SET_W-1:0] dead_sp_ff;
  logic [`AR_SET_W-1:0] dead_3p_ff;
  logic [`AR_SET_W-1:0] follow_ff;
  logic [`AR_SET_W-1:0] reclaim_ff;
  logic [`AR_SET_W-1:0] pulse_ff;
  logic [`AR_SET_W-1:0] tmr_ff;
  logic [`AR_SET_W-1:0] nxt_tmr_load;
  logic [31:0]          div_ff;
  logic                 tick;
  logic                 tmr_zero;
  logic                 rst_lock_prev_ff;
  logic                 rst_lock_pulse;
  logic [1:0]           shot_ff;
  logic                 single_pole_ff;
  logic                 force_3p_ff;
  logic [1:0]           success_ff;
  logic                 alarm_ff;
  logic                 start;
  logic                 last_shot;
  logic                 sync_one_ok;
  logic                 sync_two_ok;
  logic [`AR_ST_USED_W-1:0] status;

  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      in_ff   <= '0;
    end else begin
      meta_ff <= {reset_lockout_i, sync_ok_two_i, sync_ok_one_i,
                  cb2_closed_i, cb1_closed_i, trip_single_pole_i, trip_i};
      in_ff   <= meta_ff;
    end
  end

  // reset-lockout is taken on its rising edge only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_lock_prev_ff <= 1'b0;
    end else begin
      rst_lock_prev_ff <= in_ff.reset_lockout;
    end
  end
  assign rst_lock_pulse = in_ff.reset_lockout & ~rst_lock_prev_ff;

  //////////////////////////////////////////////////////////////////////////////
  // timebase divider: one-cycle tick enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= '0;
    end else if (div_ff == 32'(TICK_CYCLES - 1)) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
    end
  end
  assign tick = (div_ff == 32'(TICK_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////////
  // register writes; interval settings only take effect at the next timer restart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff    <= `AR_RST_CTRL;
      dead_sp_ff <= `AR_RST_DEAD_SP;
      dead_3p_ff <= `AR_RST_DEAD_3P;
      follow_ff  <= `AR_RST_FOLLOW;
      reclaim_ff <= `AR_RST_RECLAIM;
      pulse_ff   <= `AR_RST_PULSE;
    end else if (wr_i) begin
      case (addr_i)
        `AR_OFS_CTRL:    ctrl_ff    <= wdata_i[`AR_SET_W-1:0];
        `AR_OFS_DEAD_SP: dead_sp_ff <= wdata_i[`AR_SET_W-1:0];
        `AR_OFS_DEAD_3P: dead_3p_ff <= wdata_i[`AR_SET_W-1:0];
        `AR_OFS_FOLLOW:  follow_ff  <= wdata_i[`AR_SET_W-1:0];
        `AR_OFS_RECLAIM: reclaim_ff <= wdata_i[`AR_SET_W-1:0];
        `AR_OFS_PULSE:   pulse_ff   <= wdata_i[`AR_SET_W-1:0];
        default: ;
      endcase
    end
  end

  // status word seen by software
  assign status = {force_3p_ff, single_pole_ff, alarm_ff,
                   (state_ff == ar_seq_pkg::ST_LOCKOUT), success_ff,
                   2'b00, shot_ff, state_ff};

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        `AR_OFS_CTRL:    rdata_o <= {16'h0000, ctrl_ff};
        `AR_OFS_DEAD_SP: rdata_o <= {16'h0000, dead_sp_ff};
        `AR_OFS_DEAD_3P: rdata_o <= {16'h0000, dead_3p_ff};
        `AR_OFS_FOLLOW:  rdata_o <= {16'h0000, follow_ff};
        `AR_OFS_RECLAIM: rdata_o <= {16'h0000, reclaim_ff};
        `AR_OFS_PULSE:   rdata_o <= {16'h0000, pulse_ff};
        `AR_OFS_STATUS:  rdata_o <= {18'h00000, status};
        default:         rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequence decisions
  assign start     = (state_ff == ar_seq_pkg::ST_IDLE) & ctrl_ff.enable
                     & in_ff.trip;
  assign last_shot = (shot_ff >= ctrl_ff.max_shots);
  assign tmr_zero  = (tmr_ff == '0);
  // sync check applies to the first three-phase shot only
  assign sync_one_ok = !ctrl_ff.lead_one_first_shot_sync_check
                       | (shot_ff != 2'b00) | single_pole_ff
                       | in_ff.sync_ok_one;
  assign sync_two_ok = !ctrl_ff.lead_two_first_shot_sync_check
                       | (shot_ff != 2'b00) | single_pole_ff
                       | in_ff.sync_ok_two;

  // next state; a trip from dead time through second close ends the cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ar_seq_pkg::ST_IDLE: begin
        if (start) nxt_state = ar_seq_pkg::ST_WAITCLR;
      end
      ar_seq_pkg::ST_WAITCLR: begin
        if (!in_ff.trip && !in_ff.cb1_closed && !in_ff.cb2_closed) begin
          nxt_state = ar_seq_pkg::ST_DEAD;
        end
      end
      ar_seq_pkg::ST_DEAD: begin
        if (in_ff.trip) nxt_state = ar_seq_pkg::ST_LOCKOUT;
        else if (tmr_zero && sync_one_ok) nxt_state = ar_seq_pkg::ST_CLOSE1;
      end
      ar_seq_pkg::ST_CLOSE1: begin
        if (in_ff.trip) nxt_state = ar_seq_pkg::ST_LOCKOUT;
        else if (in_ff.cb1_closed) nxt_state = ar_seq_pkg::ST_FOLLOW;
        else if (tmr_zero) nxt_state = ar_seq_pkg::ST_WAITC1;
      end
      ar_seq_pkg::ST_WAITC1: begin
        if (in_ff.trip) nxt_state = ar_seq_pkg::ST_LOCKOUT;
        else if (in_ff.cb1_closed) nxt_state = ar_seq_pkg::ST_FOLLOW;
      end
      ar_seq_pkg::ST_FOLLOW: begin
        if (in_ff.trip) nxt_state = ar_seq_pkg::ST_LOCKOUT;
        else if (tmr_zero && sync_two_ok) nxt_state = ar_seq_pkg::ST_CLOSE2;
      end
      ar_seq_pkg::ST_CLOSE2: begin
        if (in_ff.trip) nxt_state = ar_seq_pkg::ST_LOCKOUT;
        else if (tmr_zero) nxt_state = ar_seq_pkg::ST_RECLAIM;
      end
      ar_seq_pkg::ST_RECLAIM: begin
        if (in_ff.trip) begin
          // another shot if allowed, otherwise the fault persists
          if (last_shot) nxt_state = ar_seq_pkg::ST_LOCKOUT;
          else nxt_state = ar_seq_pkg::ST_WAITCLR;
        end else if (tmr_zero) begin
          nxt_state = ar_seq_pkg::ST_IDLE;
        end
      end
      ar_seq_pkg::ST_LOCKOUT: begin
        if (rst_lock_pulse) nxt_state = ar_seq_pkg::ST_IDLE;
      end
      default: nxt_state = ar_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ar_seq_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timer setting picked by the state being entered
  always_comb begin
    case (nxt_state)
      ar_seq_pkg::ST_DEAD:    nxt_tmr_load = single_pole_ff ? dead_sp_ff
                                                            : dead_3p_ff;
      ar_seq_pkg::ST_FOLLOW:  nxt_tmr_load = follow_ff;
      ar_seq_pkg::ST_RECLAIM: nxt_tmr_load = reclaim_ff;
      ar_seq_pkg::ST_CLOSE1:  nxt_tmr_load = pulse_ff;
      ar_seq_pkg::ST_CLOSE2:  nxt_tmr_load = pulse_ff;
      default:                nxt_tmr_load = '0;
    endcase
  end

  // one down-counter, reloaded on every state entry, so a shot's dead
  // timer only runs once that shot reaches its dead phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_ff <= '0;
    end else if (nxt_state != state_ff) begin
      tmr_ff <= nxt_tmr_load;
    end else if (tick && !tmr_zero) begin
      tmr_ff <= tmr_ff - 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shot count and pole mode of the running sequence
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shot_ff        <= '0;
      single_pole_ff <= 1'b0;
      force_3p_ff    <= 1'b0;
    end else if (start) begin
      shot_ff        <= '0;
      single_pole_ff <= ctrl_ff.single_phase_mode & in_ff.trip_single_pole;
      force_3p_ff    <= 1'b1;
    end else if (state_ff == ar_seq_pkg::ST_RECLAIM &&
                 nxt_state == ar_seq_pkg::ST_WAITCLR) begin
      shot_ff        <= shot_ff + 2'b01;
      single_pole_ff <= 1'b0;
    end else if (nxt_state == ar_seq_pkg::ST_IDLE ||
                 nxt_state == ar_seq_pkg::ST_LOCKOUT) begin
      force_3p_ff    <= 1'b0;
      single_pole_ff <= 1'b0;
    end
  end

  // success flags: set on a quiet reclaim end, cleared by a new start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      success_ff <= '0;
    end else if (state_ff == ar_seq_pkg::ST_RECLAIM &&
                 nxt_state == ar_seq_pkg::ST_IDLE) begin
      success_ff <= 2'b11;
    end else if (start || rst_lock_pulse) begin
      success_ff <= '0;
    end
  end

  // alarm raised on lockout entry; the set beats a same-cycle reset pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_ff <= 1'b0;
    end else if (nxt_state == ar_seq_pkg::ST_LOCKOUT &&
                 state_ff != ar_seq_pkg::ST_LOCKOUT) begin
      alarm_ff <= 1'b1;
    end else if (rst_lock_pulse) begin
      alarm_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs; in-progress is combinational so it rises with the trip
  assign reclose_in_progress_o = {2{start |
                                 ((state_ff != ar_seq_pkg::ST_IDLE) &
                                  (state_ff != ar_seq_pkg::ST_LOCKOUT))}};
  assign close_one_o        = (state_ff == ar_seq_pkg::ST_CLOSE1);
  assign close_two_o        = (state_ff == ar_seq_pkg::ST_CLOSE2);
  assign success_o          = success_ff;
  assign lockout_o          = (state_ff == ar_seq_pkg::ST_LOCKOUT);
  assign alarm_o            = alarm_ff;
  assign force_three_pole_o = force_3p_ff & (shot_ff != 2'b00 |
                              !single_pole_ff);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb_main @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_reclaim_trip;
    state_ff == ar_seq_pkg::ST_RECLAIM && in_ff.trip && last_shot
    |=> lockout_o && reclose_in_progress_o == 2'b00 ##1 lockout_o;
  endproperty
  a_reclaim_trip: assert property (p_reclaim_trip)
    else $error("reclaim trip did not lock out");

  property p_rip_with_trip;
    start |-> reclose_in_progress_o == 2'b11;
  endproperty
  a_rip_with_trip: assert property (p_rip_with_trip)
    else $error("in-progress late on trip");

  property p_close_one_src;
    $rose(close_one_o) |-> $past(state_ff) == ar_seq_pkg::ST_DEAD
                           && !close_two_o;
  endproperty
  a_close_one_src: assert property (p_close_one_src)
    else $error("leader close not after dead time");

  property p_follow_start;
    $rose(state_ff == ar_seq_pkg::ST_FOLLOW) |-> $past(in_ff.cb1_closed)
      && tmr_ff == follow_ff;
  endproperty
  a_follow_start: assert property (p_follow_start)
    else $error("follower timer start wrong");

  property p_close_two_src;
    $rose(close_two_o) |-> $past(state_ff) == ar_seq_pkg::ST_FOLLOW
                           && $past(tmr_zero);
  endproperty
  a_close_two_src: assert property (p_close_two_src)
    else $error("follower close not after follower time");

  property p_reclaim_start;
    $fell(close_two_o) && state_ff == ar_seq_pkg::ST_RECLAIM
    |-> tmr_ff == reclaim_ff && $past(tmr_zero);
  endproperty
  a_reclaim_start: assert property (p_reclaim_start)
    else $error("reclaim not started at close pulse end");

  property p_success;
    state_ff == ar_seq_pkg::ST_RECLAIM && tmr_zero && !in_ff.trip
    |=> success_o == 2'b11 && !lockout_o;
  endproperty
  a_success: assert property (p_success)
    else $error("success not flagged");

  property p_three_pole_later;
    state_ff != ar_seq_pkg::ST_IDLE && state_ff != ar_seq_pkg::ST_LOCKOUT
    && shot_ff != 2'b00
    |-> force_three_pole_o && !single_pole_ff;
  endproperty
  a_three_pole_later: assert property (p_three_pole_later)
    else $error("later shot not three-pole");

  property p_dead_select;
    $rose(state_ff == ar_seq_pkg::ST_DEAD)
    |-> tmr_ff == (single_pole_ff ? dead_sp_ff : dead_3p_ff);
  endproperty
  a_dead_select: assert property (p_dead_select)
    else $error("wrong dead interval loaded");

  property p_sync_wait;
    $rose(close_one_o) && shot_ff == 2'b00 && !single_pole_ff
      && ctrl_ff.lead_one_first_shot_sync_check |-> $past(in_ff.sync_ok_one);
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("first shot closed without sync check");

  property p_lock_hold;
    lockout_o && !rst_lock_pulse |=> lockout_o && alarm_o;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lockout left without reset pulse");

endmodule

// ===== dv/cb_pair_model.sv
// Purpose: behavioural pair of breakers facing the sequencer
// Assumes: trip held high by the bench until both breakers report open
// Notes:   breaker one opens first; a close needs the command held
module cb_pair_model #(
  parameter int CLOSE_DLY = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic trip_i,
  input  wire logic close_one_i,
  input  wire logic close_two_i,
  input  wire logic man_close_i,
  output logic      cb1_closed_o,
  output logic      cb2_closed_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int trip_cnt;
  int c1_cnt;
  int c2_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // how long each command has been held; a dropped command starts over
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trip_cnt <= 0;
      c1_cnt   <= 0;
      c2_cnt   <= 0;
    end else begin
      trip_cnt <= trip_i ? trip_cnt + 1 : 0;
      c1_cnt   <= close_one_i ? c1_cnt + 1 : 0;
      c2_cnt   <= close_two_i ? c2_cnt + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // breaker two opens later, so the fault clears only when both are open
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cb1_closed_o <= 1'b1;
      cb2_closed_o <= 1'b1;
    end else begin
      if (trip_cnt == 2) begin
        cb1_closed_o <= 1'b0;
      end else if (c1_cnt == CLOSE_DLY - 1 || man_close_i) begin
        cb1_closed_o <= 1'b1;
      end
      if (trip_cnt == 4) begin
        cb2_closed_o <= 1'b0;
      end else if (c2_cnt == CLOSE_DLY - 1 || man_close_i) begin
        cb2_closed_o <= 1'b1;
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the two-breaker reclose sequencer
// Assumes: tick shortened to 4 clocks; intervals set to a few ticks
// Notes:   bounds allow one tick of phase plus sync and breaker delay
`include "ar_seq_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int T   = 4;
  localparam int DSP = 3;
  localparam int D3P = 6;
  localparam int FOL = 2;
  localparam int RCL = 5;
  localparam int PUL = 2;

  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        trip_i = 1'b0;
  logic        tsp_i = 1'b0;
  logic        sok1_i = 1'b0;
  logic        sok2_i = 1'b0;
  logic        rlo_i = 1'b0;
  logic        man_i = 1'b0;
  logic [31:0] rdata_o;
  logic        cb1_i;
  logic        cb2_i;
  logic [1:0]  rip_o;
  logic        c1_o;
  logic        c2_o;
  logic [1:0]  succ_o;
  logic        lock_o;
  logic        alarm_o;
  logic        f3p_o;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;

  ar_seq #(.TICK_CYCLES(T)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trip_i(trip_i),
    .trip_single_pole_i(tsp_i), .cb1_closed_i(cb1_i), .cb2_closed_i(cb2_i),
    .sync_ok_one_i(sok1_i), .sync_ok_two_i(sok2_i),
    .reset_lockout_i(rlo_i), .reclose_in_progress_o(rip_o),
    .close_one_o(c1_o), .close_two_o(c2_o), .success_o(succ_o),
    .lockout_o(lock_o), .alarm_o(alarm_o), .force_three_pole_o(f3p_o));

  cb_pair_model #(.CLOSE_DLY(3)) breakers (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .trip_i(trip_i),
    .close_one_i(c1_o), .close_two_i(c2_o), .man_close_i(man_i),
    .cb1_closed_o(cb1_i), .cb2_closed_o(cb2_i));

  always #4 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers: sampling, comparison, register port, bounded waits
  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and still ends through the verdict
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic rng(input int n, input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= {16'h0, d};
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return c1_o;
      1: return c2_o;
      2: return &succ_o;
      3: return lock_o;
      4: return ~c2_o;
      default: return ~cb1_i & ~cb2_i;
    endcase
  endfunction

  task automatic wait_for(input int k, input int lim, output int n);
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
  endtask

  // raise a trip, hold it until both breakers are open, then let it reset
  task automatic trip_open(input logic sp, input logic idle);
    int n;
    @(posedge clk_i);
    trip_i <= 1'b1;
    tsp_i  <= sp;
    tick();
    if (idle) chk(32'(rip_o), 32'h0);
    tick();
    tick();
    chk(32'(rip_o), 32'h3);
    wait_for(5, 40, n);
    @(posedge clk_i);
    trip_i <= 1'b0;
  endtask

  task automatic close_seq(input int d);
    int n;
    wait_for(0, 400, n);
    rng(n, d * T, d * T + T + 6);
    chk(32'(c2_o), 32'h0);
    wait_for(1, 100, n);
    rng(n, FOL * T, FOL * T + T + 8);
    wait_for(4, 100, n);
    rng(n, PUL * T - T, PUL * T + T);
  endtask

  task automatic reclaim_ok;
    int n;
    wait_for(2, 200, n);
    rng(n, RCL * T - 2, RCL * T + T + 2);
    chk(32'(succ_o), 32'h3);
    chk(32'(rip_o), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [7:0]  ofs [8] = '{`AR_OFS_CTRL, `AR_OFS_DEAD_SP, `AR_OFS_DEAD_3P,
      `AR_OFS_FOLLOW, `AR_OFS_RECLAIM, `AR_OFS_PULSE, `AR_OFS_STATUS, 8'h1c};
    logic [15:0] rv [8] = '{`AR_RST_CTRL, `AR_RST_DEAD_SP, `AR_RST_DEAD_3P,
      `AR_RST_FOLLOW, `AR_RST_RECLAIM, `AR_RST_PULSE, 16'h0000, 16'h0000};
    int          set [5] = '{DSP, D3P, FOL, RCL, PUL};
    for (int i = 0; i < 8; i++) begin
      reg_rd(ofs[i], d);
      chk(d, {16'h0, rv[i]});
    end
    for (int i = 0; i < 5; i++) begin
      reg_wr(ofs[i + 1], 16'(set[i]));
    end
    reg_rd(`AR_OFS_DEAD_3P, d);
    chk(d, 32'(D3P));
  endtask

  // sync check not selected, so closing goes ahead without it
  task automatic t_transient;
    trip_open(1'b0, 1'b1);
    close_seq(D3P);
    reclaim_ok();
  endtask

  task automatic t_evolving;
    int n;
    trip_open(1'b0, 1'b1);
    close_seq(D3P);
    @(posedge clk_i);
    trip_i <= 1'b1;
    wait_for(3, 10, n);
    chk(32'(lock_o), 32'h1);
    chk(32'(rip_o), 32'h0);
    chk(32'(alarm_o), 32'h1);
    wait_for(5, 40, n);
    @(posedge clk_i);
    trip_i <= 1'b0;
    repeat (20) tick();
    chk(32'(lock_o), 32'h1);
    @(posedge clk_i);
    rlo_i <= 1'b1;
    @(posedge clk_i);
    rlo_i <= 1'b0;
    repeat (6) tick();
    chk(32'(lock_o), 32'h0);
    chk(32'(alarm_o), 32'h0);
    @(posedge clk_i);
    man_i <= 1'b1;
    @(posedge clk_i);
    man_i <= 1'b0;
    repeat (4) tick();
  endtask

  // second shot must fall back to three-pole and the longer dead time
  task automatic t_multishot;
    reg_wr(`AR_OFS_CTRL, 16'h0013);
    trip_open(1'b1, 1'b1);
    chk(32'(f3p_o), 32'h0);
    close_seq(DSP);
    trip_open(1'b1, 1'b0);
    chk(32'(lock_o), 32'h0);
    chk(32'(f3p_o), 32'h1);
    close_seq(D3P);
    reclaim_ok();
  endtask

  task automatic t_sync;
    int n;
    reg_wr(`AR_OFS_CTRL, 16'h000d);
    trip_open(1'b0, 1'b1);
    wait_for(0, D3P * T + 40, n);
    chk(32'(c1_o), 32'h0);
    @(posedge clk_i);
    sok1_i <= 1'b1;
    wait_for(0, 8, n);
    chk(32'(c1_o), 32'h1);
    wait_for(1, FOL * T + 40, n);
    chk(32'(c2_o), 32'h0);
    @(posedge clk_i);
    sok2_i <= 1'b1;
    wait_for(1, 8, n);
    chk(32'(c2_o), 32'h1);
    wait_for(2, 300, n);
    chk(32'(succ_o), 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick();
    t_regs();
    t_transient();
    t_evolving();
    t_multishot();
    t_sync();
    report_and_stop();
  end
endmodule
